/* design/spm_pkg.sv */
// spm_pkg: constants shared by the serial peripheral port core and its shifter.
// assumes a 250 MHz system clock; no register bus, controls are plain ports.
package spm_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    // fastest serial bit rate in bits per second
    localparam int MAX_BIT_RATE = 2000000;
    localparam int BIT_PERIOD_PS = 500000;
    // half bit period in clocks, rounded up so the rate never exceeds the limit
    localparam int HALF_BIT_CYCLES = (BIT_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BYTE_BITS = 8;
    localparam int SS_DIR_BIT = 5;
    localparam logic [7:0] RX_RESET = 8'h00;
    typedef enum logic [1:0]
    {
        SPM_IDLE = 2'b00,
        SPM_LOW = 2'b01,
        SPM_HIGH = 2'b10
    } spm_state_t;
endpackage

/* design/spm_shift.sv */
// spm_shift: one byte shift register, msb first, loads and shifts on strobes.
// assumes strobes come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module spm_shift #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_data,
    input wire logic sample,
    input wire logic sample_bit,
    input wire logic shift,
    output logic out_bit,
    output logic [WIDTH-1:0] data
);
    logic [WIDTH-1:0] sreg;
    logic [WIDTH-1:0] next_sreg;
    logic held;
    logic next_held;

    initial
    begin
        if (WIDTH < 2) $error("spm_shift width too small");
    end

    always_comb
    begin
        next_sreg = sreg;
        next_held = held;
        if (load)
            next_sreg = load_data;
        else if (sample)
            next_held = sample_bit;
        else if (shift)
            next_sreg = {sreg[WIDTH-2:0], held};
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sreg <= '0;
            held <= 1'b0;
        end
        else
        begin
            sreg <= next_sreg;
            held <= next_held;
        end
    end

    assign out_bit = sreg[WIDTH-1];
    assign data = sreg;
endmodule
`default_nettype wire

/* design/spm_core.sv */
// spm_core: master or slave serial peripheral port, pin level, mode 0 timing.
// assumes pins come from outside; all pin inputs pass two flip-flops first.
`timescale 1ns/100ps
`default_nettype none
module spm_core (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic port_enable,
    input wire logic master_select_bit,
    input wire logic intr_enable,
    input wire logic [7:0] port_direction_reg,
    input wire logic ss_gpo_value,
    input wire logic tx_write,
    input wire logic [7:0] tx_data,
    input wire logic clear_done,
    input wire logic clear_fault,
    input wire logic sck_in,
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic ss_b_in,
    output logic sck_out,
    output logic sck_oe,
    output logic mosi_out,
    output logic mosi_oe,
    output logic miso_out,
    output logic miso_oe,
    output logic ss_b_out,
    output logic ss_b_oe,
    output logic [7:0] rx_data,
    output logic xfer_done,
    output logic mode_fault,
    output logic busy,
    output logic irq
);
    localparam int HB = spm_pkg::HALF_BIT_CYCLES;
    localparam logic [7:0] HB_M1 = 8'(HB - 1);
    localparam logic [3:0] LAST_BIT = 4'(spm_pkg::BYTE_BITS - 1);
    localparam int SS_DIR = spm_pkg::SS_DIR_BIT;

    logic [2:0] sck_s, next_sck_s;
    logic [1:0] mosi_s, miso_s, ss_s, next_mosi_s, next_miso_s, next_ss_s;
    spm_pkg::spm_state_t state, next_state;
    logic [7:0] hcnt, next_hcnt;
    logic [3:0] bitn, next_bitn;
    logic [7:0] next_rx_data;
    logic next_xfer_done, next_mode_fault, next_busy, next_irq;
    logic next_sck_out, next_sck_oe, next_mosi_oe, next_miso_oe;
    logic next_ss_b_out, next_ss_b_oe, next_mosi_out, next_miso_out;
    logic sh_load, sh_sample, sh_shift, sh_bit, sh_out, done_ev, byte_end, next_byte_end;
    logic [7:0] sh_data;
    logic sck_rise, sck_fall, ss_lo, ss_is_input, slave_sel;

    // two stage synchronisers; bit 0 first stage, bit 1 stable, sck bit 2 finds edges
    always_comb
    begin
        next_sck_s = {sck_s[1:0], sck_in};
        next_mosi_s = {mosi_s[0], mosi_in};
        next_miso_s = {miso_s[0], miso_in};
        next_ss_s = {ss_s[0], ss_b_in};
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sck_s <= 3'h0;
            mosi_s <= 2'h0;
            miso_s <= 2'h0;
            ss_s <= 2'h3;
        end
        else
        begin
            sck_s <= next_sck_s;
            mosi_s <= next_mosi_s;
            miso_s <= next_miso_s;
            ss_s <= next_ss_s;
        end
    end
    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];
    assign ss_lo = ~ss_s[1];
    assign ss_is_input = ~master_select_bit | ~port_direction_reg[spm_pkg::SS_DIR_BIT];
    assign slave_sel = port_enable & ~master_select_bit & ss_lo;

    spm_shift #(
        .WIDTH(spm_pkg::BYTE_BITS)
    ) u_shift (
        .clk(clk),
        .rst_b(rst_b),
        .load(sh_load),
        .load_data(tx_data),
        .sample(sh_sample),
        .sample_bit(sh_bit),
        .shift(sh_shift),
        .out_bit(sh_out),
        .data(sh_data)
    );

    always_comb
    begin
        next_state = state;
        next_hcnt = hcnt;
        next_bitn = bitn;
        sh_load = 1'b0;
        sh_sample = 1'b0;
        sh_shift = 1'b0;
        sh_bit = master_select_bit ? miso_s[1] : mosi_s[1];
        done_ev = 1'b0;
        next_sck_out = 1'b0;
        case (state)
            spm_pkg::SPM_IDLE:
            begin
                next_bitn = 4'h0;
                next_hcnt = 8'h00;
                if (tx_write && port_enable && !(master_select_bit && ss_is_input && ss_lo))
                    sh_load = 1'b1;
                if ((sh_load && master_select_bit) || slave_sel)
                    next_state = spm_pkg::SPM_LOW;
            end
            spm_pkg::SPM_LOW:
            begin
                if (master_select_bit)
                begin
                    next_hcnt = hcnt + 8'h01;
                    if (hcnt == HB_M1)
                    begin
                        next_hcnt = 8'h00;
                        sh_sample = 1'b1;
                        next_state = spm_pkg::SPM_HIGH;
                    end
                end
                else if (!slave_sel)
                    next_state = spm_pkg::SPM_IDLE;
                else if (sck_rise)
                begin
                    sh_sample = 1'b1;
                    next_state = spm_pkg::SPM_HIGH;
                end
            end
            spm_pkg::SPM_HIGH:
            begin
                next_sck_out = master_select_bit;
                if (master_select_bit ? (hcnt == HB_M1) : sck_fall)
                begin
                    next_hcnt = 8'h00;
                    sh_shift = 1'b1;
                    next_bitn = bitn + 4'h1;
                    next_sck_out = 1'b0;
                    next_state = spm_pkg::SPM_LOW;
                    if (bitn == LAST_BIT)
                    begin
                        done_ev = 1'b1;
                        next_state = spm_pkg::SPM_IDLE;
                    end
                end
                else if (master_select_bit)
                    next_hcnt = hcnt + 8'h01;
                else if (!slave_sel)
                    next_state = spm_pkg::SPM_IDLE;
            end
            default:
                next_state = spm_pkg::SPM_IDLE;
        endcase
        if (!port_enable)
            next_state = spm_pkg::SPM_IDLE;
        if (master_select_bit && ss_is_input && ss_lo && state != spm_pkg::SPM_IDLE)
            next_state = spm_pkg::SPM_IDLE;
    end

    always_comb
    begin
        next_byte_end = done_ev;
        next_xfer_done = (xfer_done & ~clear_done) | byte_end;
        next_rx_data = byte_end ? sh_data : rx_data;
        // low select on master is fault when the select pin is an input
        next_mode_fault = (mode_fault & ~clear_fault)
            | (port_enable & master_select_bit & ss_is_input & ss_lo);
        next_irq = intr_enable & (next_xfer_done | next_mode_fault);
        next_busy = next_state != spm_pkg::SPM_IDLE;
        next_sck_oe = port_enable & master_select_bit;
        next_mosi_oe = port_enable & master_select_bit;
        next_mosi_out = (next_state == spm_pkg::SPM_IDLE) ? 1'b0 : sh_out;
        next_miso_out = sh_out;
        next_miso_oe = slave_sel;
        next_ss_b_oe = ~ss_is_input;
        next_ss_b_out = ss_gpo_value;
        if (sh_load)
        begin
            next_mosi_out = tx_data[7];
            next_miso_out = tx_data[7];
        end
        else if (sh_shift)
        begin
            next_mosi_out = sh_data[6];
            next_miso_out = sh_data[6];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= spm_pkg::SPM_IDLE;
            hcnt <= 8'h00;
            bitn <= 4'h0;
            rx_data <= spm_pkg::RX_RESET;
            xfer_done <= 1'b0;
            mode_fault <= 1'b0;
            busy <= 1'b0;
            irq <= 1'b0;
            byte_end <= 1'b0;
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            ss_b_out <= 1'b1;
            ss_b_oe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            hcnt <= next_hcnt;
            bitn <= next_bitn;
            rx_data <= next_rx_data;
            xfer_done <= next_xfer_done;
            mode_fault <= next_mode_fault;
            busy <= next_busy;
            irq <= next_irq;
            byte_end <= next_byte_end;
            sck_out <= next_sck_out;
            sck_oe <= next_sck_oe;
            mosi_out <= next_mosi_out;
            mosi_oe <= next_mosi_oe;
            miso_out <= next_miso_out;
            miso_oe <= next_miso_oe;
            ss_b_out <= next_ss_b_out;
            ss_b_oe <= next_ss_b_oe;
        end
    end

    a_slave_ss_in: assert property (@(posedge clk) disable iff (!rst_b)
        !master_select_bit |=> !ss_b_oe) else $error("select driven in slave role");
    a_desel_float: assert property (@(posedge clk) disable iff (!rst_b)
        (!master_select_bit && !ss_lo) |=> !miso_oe) else $error("miso driven while deselected");
    a_gpo_follow: assert property (@(posedge clk) disable iff (!rst_b)
        (master_select_bit && port_direction_reg[SS_DIR]) |=> (ss_b_oe && ss_b_out == $past(ss_gpo_value)))
        else $error("select output not following value");
    a_fault_set: assert property (@(posedge clk) disable iff (!rst_b)
        (port_enable && master_select_bit && !port_direction_reg[SS_DIR] && ss_lo) |=> mode_fault)
        else $error("mode fault missed");
    a_fault_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (mode_fault && !clear_fault) |=> mode_fault) else $error("mode fault lost");
    a_done_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (xfer_done && !clear_done) |=> xfer_done) else $error("done flag lost");
    a_master_sck: assert property (@(posedge clk) disable iff (!rst_b)
        (port_enable && master_select_bit) |=> sck_oe) else $error("master clock not driven");
    a_sck_width: assert property (@(posedge clk) disable iff (!rst_b)
        ($rose(sck_out) && master_select_bit && port_enable && !ss_is_input)
        |-> sck_out [*8]) else $error("serial clock high too short");
    a_irq_mask: assert property (@(posedge clk) disable iff (!rst_b)
        irq |-> $past(intr_enable)) else $error("interrupt without enable");
endmodule
`default_nettype wire

/* bench/spm_peer.sv */
// spm_peer: far-side model, slave to a master dut, master to a slave dut.
// assumes mode 0; as master it clocks at the 125 ns link period.
`timescale 1ns/100ps
`default_nettype none
module spm_peer (
    input wire logic master,
    input wire logic go,
    input wire logic [7:0] tx,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic ss_b,
    output logic sck_p,
    output logic mosi_p,
    output logic miso_p,
    output logic sel_b,
    output logic [7:0] rx
);
    logic [7:0] sr;
    initial
    begin
        {sck_p, mosi_p, miso_p, sel_b, sr, rx} = {4'h1, 16'h0000};
    end
    // byte out while byte in, peer masters only a slave dut
    always @(posedge go)
    begin
        sr = tx;
        if (!master)
            miso_p = sr[7];
        else
        begin
            sel_b = 0;
            repeat (8)
            begin
                mosi_p = sr[7];
                #62.5 sck_p = 1;
                rx = {rx[6:0], miso};
                #62.5 sck_p = 0;
                sr = sr << 1;
            end
            #62.5 sel_b = 1;
            // a released line must not keep its last value
            mosi_p = ~mosi_p;
        end
    end
    always @(posedge sck)
        if (!master && !ss_b)
            rx = {rx[6:0], mosi};
    always @(negedge sck)
        if (!master && !ss_b)
        begin
            sr = sr << 1;
            miso_p = sr[7];
        end
    always @(posedge ss_b)
        if (!master)
            miso_p = ~miso_p;
endmodule
`default_nettype wire

/* bench/spi_pin_mode_control_tb.sv */
// spi_pin_mode_control_tb: self-checking bench for spm_core with spm_peer.
// assumes mode 0 and the pin syncing delays given by the core.
`timescale 1ns/100ps
`default_nettype none
module spi_pin_mode_control_tb;
    logic clk, rst_b, en, msel, ie, gpo, txw, clrd, clrf, ss_tb, p_mst, p_go, done_q;
    logic [7:0] dir, txd, ptx, rx, prx;
    logic sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e, ss_o, ss_e;
    logic done, fault, busy, irq, p_sck, p_mosi, p_miso, p_sel;
    logic [7:0] q[$];
    int errors, comparisons, rises;
    realtime last_rise;
    wire logic sck_l = sck_e ? sck_o : p_sck;
    wire logic mosi_l = mosi_e ? mosi_o : p_mosi;
    wire logic miso_l = miso_e ? miso_o : p_miso;
    wire logic ss_l = ss_e ? ss_o : (p_mst ? (p_sel | ss_tb) : ss_tb);
    spm_core dut (.clk(clk), .rst_b(rst_b), .port_enable(en), .master_select_bit(msel),
        .intr_enable(ie), .port_direction_reg(dir), .ss_gpo_value(gpo), .tx_write(txw),
        .tx_data(txd), .clear_done(clrd), .clear_fault(clrf), .sck_in(sck_l),
        .mosi_in(mosi_l), .miso_in(miso_l), .ss_b_in(ss_l), .sck_out(sck_o), .sck_oe(sck_e),
        .mosi_out(mosi_o), .mosi_oe(mosi_e), .miso_out(miso_o), .miso_oe(miso_e),
        .ss_b_out(ss_o), .ss_b_oe(ss_e), .rx_data(rx), .xfer_done(done),
        .mode_fault(fault), .busy(busy), .irq(irq));
    spm_peer peer (.master(p_mst), .go(p_go), .tx(ptx), .sck(sck_l), .mosi(mosi_l),
        .miso(miso_l), .ss_b(ss_l), .sck_p(p_sck), .mosi_p(p_mosi), .miso_p(p_miso),
        .sel_b(p_sel), .rx(prx));
    task check(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task byte_go(input logic [7:0] d, input logic [7:0] pd);
        int i;
        ptx = pd;
        p_go = 1;
        step(1);
        p_go = 0;
        if (msel)
        begin
            txd = d;
            txw = 1;
            step(1);
            txw = 0;
            check(busy === 1'b1, "busy during byte");
        end
        for (i = 0; i < 3000 && done !== 1'b1; i++)
            step(1);
    endtask
    task clear_flags;
        {clrd, clrf} = 2'b11;
        step(1);
        {clrd, clrf} = 2'b00;
        step(1);
    endtask
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #100000;
        errors++;
        final_report();
    end
    // no two clock rises closer than one 2 Mb/s bit
    always @(posedge sck_o)
    begin
        if (last_rise > 0 && $realtime - last_rise < 500.0)
            check(0, "serial clock too fast");
        last_rise = $realtime;
        rises++;
    end
    // watcher: each rising done takes the oldest expected byte
    always @(posedge clk)
    begin
        done_q <= done;
        if (done === 1'b1 && done_q !== 1'b1)
            check(q.size() > 0 && rx === q.pop_front(), "received byte");
    end
    initial
    begin
        {rst_b, en, msel, ie, gpo, txw, clrd, clrf, p_mst, p_go} = 10'h000;
        {dir, txd, ptx, ss_tb, rises} = {24'h000000, 1'b1, 32'h0};
        last_rise = 0.0;
        void'($urandom(32'h827f));
        repeat (4) @(posedge clk);
        #1 rst_b = 1;
        step(2);
        check(ss_e === 1'b0 && done === 1'b0, "reset pins");
        {en, msel, ie, dir, gpo} = {3'b111, 8'h20, 1'b1};
        step(3);
        check(ss_e === 1'b1 && ss_o === 1'b1 && mosi_e === 1'b1, "select drives one");
        gpo = 0;
        step(3);
        check(ss_o === 1'b0 && busy === 1'b0, "select drives zero");
        repeat (3)
        begin
            txd = 8'($urandom);
            q.push_back(8'($urandom));
            rises = 0;
            byte_go(txd, q[$]);
            check(done === 1'b1 && irq === 1'b1, "done and irq");
            check(rises == 8 && prx === txd, "master byte");
            clear_flags();
        end
        $display("test master done");
        dir = 8'h00;
        ss_tb = 0;
        step(5);
        check(ss_e === 1'b0 && fault === 1'b1 && irq === 1'b1, "mode fault");
        ss_tb = 1;
        step(6);
        check(fault === 1'b1, "fault sticky");
        clear_flags();
        check(fault === 1'b0 && irq === 1'b0, "fault cleared");
        $display("test fault done");
        {msel, p_mst, dir} = {2'b01, 8'h20};
        step(3);
        check(ss_e === 1'b0 && sck_e === 1'b0 && mosi_e === 1'b0, "slave select input");
        byte_go(8'h00, 8'($urandom));
        check(miso_e === 1'b0 && done === 1'b0 && busy === 1'b0, "deselected");
        ss_tb = 0;
        txd = 8'($urandom);
        txw = 1;
        step(1);
        txw = 0;
        q.push_back(8'($urandom));
        byte_go(8'h00, q[$]);
        check(done === 1'b1 && prx === txd, "slave byte");
        step(2);
        $display("test slave done");
        final_report();
    end
endmodule
`default_nettype wire
